// file: include/omfc_regs.vh
// Overview of operation
// [RULE1] With warm-up hold enabled, hold outputs off fifteen minutes from power-on.
// [RULE2] During the hold both transmit and receive outputs stay muted.
// [RULE3] At hold expiry outputs turn on if normal enable conditions hold.
// [RULE4] Clearing the hold option ends a running hold at once.
// [RULE5] Recovery off: a fault mute persists after the fault clears until unmute command.
// [RULE6] Recovery on: output unmutes automatically when its fault clears.
// [RULE7] Fault occurrences counted per type; fifth occurrence clears recovery, output stays muted. A one-cycle fifth fault still auto-unmutes.
// [RULE8] Amplifier feed current source has user on/off setting, default off.
// [RULE9] Calibrate captures feed current; alarm when it leaves configured 20-50 percent window.
// [RULE10] Window value 99 disables detection and is the default.
// [RULE11] Select bit routes window alarm onto summary fault relay; default 0 keeps it off.
// [RULE12] Switch unit starts in automatic mode at power-up.
// [RULE13] Automatic mode: switch unit brings offline unit online when online unit faults.
// [RULE14] Manual mode: switch unit moves transfer switches only on toggle or contact input.
// [RULE15] Redundancy mode data: 1 automatic, 0 manual, forwarded to switch unit.
// [RULE16] Automatic mode toggle switches over only if offline unit is unfaulted.
// [RULE17] Manual mode toggle always switches over.
// [RULE18] Device answers only its unit address, 0001 to 9999, default 0001.
// [RULE19] Link rate selectable 1200 to 38400 baud, default 9600.
// [RULE20] Calendar clock settable; each logged event is stamped with date and time.
// [RULE21] Tx on needs no fault, unmuted, power stage on; Rx needs no fault, unmuted.
// [RULE22] Re-enabling recovery clears the per-fault occurrence counters.
`ifndef OMFC_REGS_VH
`define OMFC_REGS_VH
`define OMFC_HOLD_MINUTES 15
`define OMFC_CLK_HZ 20000000
`define OMFC_TICK_CYCLES (`OMFC_CLK_HZ)
`define OMFC_HOLD_SECONDS (`OMFC_HOLD_MINUTES * 60)
`define OMFC_FAULT_LIMIT 3'd5
`define OMFC_WIN_MIN 7'd20
`define OMFC_WIN_MAX 7'd50
`define OMFC_WIN_OFF 7'd99
`define OMFC_ADDR_MIN 14'd1
`define OMFC_ADDR_MAX 14'd9999
`define OMFC_ADDR_RST 14'd1
`define OMFC_RATE_1200 3'd0
`define OMFC_RATE_38400 3'd5
`define OMFC_RATE_RST 3'd3
`define OMFC_MODE_AUTO 1'b1
`define OMFC_MODE_MANUAL 1'b0
`endif

// file: src/omfc_fault_slot.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Per-fault latch and occurrence counter
module omfc_fault_slot (
	input wire clk_sys,
	input wire reset_n,
	input wire fault_raw,
	input wire recovery_on,
	input wire recovery_rearm,
	input wire unmute_cmd,
	output reg latched_q,
	output reg limit_hit_q
);
`include "omfc_regs.vh"
	reg s1_q;
	reg s2_q;
	reg s3_q;
	reg [2:0] count_q;
	wire rise;
	assign rise = s2_q & ~s3_q;
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			count_q <= 3'h0;
			latched_q <= 1'b0;
			limit_hit_q <= 1'b0;
		end else begin
			s1_q <= fault_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			limit_hit_q <= 1'b0;
			// [RULE22] Rearm clears count
			if (recovery_rearm) begin
				count_q <= 3'h0;
			// [RULE7] Count occurrences
			end else if (rise && count_q != `OMFC_FAULT_LIMIT) begin
				count_q <= count_q + 3'h1;
				if (count_q + 3'h1 == `OMFC_FAULT_LIMIT)
					limit_hit_q <= 1'b1;
			end
			if (s2_q) begin
				latched_q <= 1'b1;
			// [RULE6] Auto unmute on clear
			end else if (recovery_on && !(rise || (count_q == 3'h4 && s2_q))) begin
				latched_q <= 1'b0;
			// [RULE5] Hold until unmute
			end else if (unmute_cmd) begin
				latched_q <= 1'b0;
			end
		end
	end
endmodule // omfc_fault_slot
`default_nettype wire

// file: src/omfc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "omfc_regs.vh"
module omfc_top #(
	parameter NFAULT = 4,
	parameter HOLD_SECONDS = `OMFC_HOLD_SECONDS,
	parameter TICK_CYCLES = `OMFC_TICK_CYCLES
) (
	input wire clk_sys,
	input wire reset_n,
	input wire cmd_valid,
	input wire [13:0] cmd_address,
	input wire warmup_hold_enable,
	input wire auto_fault_recovery_set,
	input wire auto_fault_recovery_val,
	input wire lna_feed_source_set,
	input wire lna_feed_source_val,
	input wire lna_calibrate,
	input wire lna_window_width_set,
	input wire [6:0] lna_window_width_val,
	input wire lna_alarm_relay_select_set,
	input wire lna_alarm_relay_select_val,
	input wire redundancy_mode_set,
	input wire redundancy_mode_val,
	input wire redundancy_toggle,
	input wire unit_address_set,
	input wire [13:0] unit_address_val,
	input wire link_rate_set,
	input wire [2:0] link_rate_val,
	input wire calendar_date_set,
	input wire [23:0] calendar_date_val,
	input wire clock_hms_set,
	input wire [16:0] clock_hms_val,
	input wire tx_power_stage_set,
	input wire tx_power_stage_val,
	input wire tx_mute_set,
	input wire tx_mute_val,
	input wire rx_mute_set,
	input wire rx_mute_val,
	input wire [NFAULT-1:0] tx_fault_pin,
	input wire [NFAULT-1:0] rx_fault_pin,
	input wire [9:0] lna_current,
	input wire other_fault_pin,
	input wire log_event,
	output reg tx_output_on_q,
	output reg rx_output_on_q,
	output reg tx_output_muted,
	output reg rx_output_muted,
	output reg hold_active_q,
	output reg auto_fault_recovery_q,
	output reg lna_feed_source_on,
	output reg lna_alarm_q,
	output reg summary_fault_q,
	output reg redundancy_mode_q,
	output reg redundancy_toggle_q,
	output reg [13:0] unit_address_q,
	output reg [2:0] link_rate_q,
	output reg [23:0] stamp_date_q,
	output reg [16:0] stamp_hms_q,
	output reg stamp_valid_q
);
	// ==========================================================
	// Synchronisers
	reg whe1_q, whe2_q, ofl1_q, ofl2_q;
	reg [9:0] cur1_q, cur2_q, cur3_q;
	// ==========================================================
	// Command qualification
	wire hit;
	// [RULE18] Address match
	assign hit = cmd_valid && (cmd_address == unit_address_q);
	// ==========================================================
	// Fault slots
	wire [2*NFAULT-1:0] latched;
	wire [2*NFAULT-1:0] limit_hit;
	wire [2*NFAULT-1:0] fault_vec;
	reg rearm_q;
	assign fault_vec = {rx_fault_pin, tx_fault_pin};
	genvar g;
	generate
		for (g = 0; g < 2*NFAULT; g = g + 1) begin : slot
			omfc_fault_slot u_slot (
				.clk_sys(clk_sys),
				.reset_n(reset_n),
				.fault_raw(fault_vec[g]),
				.recovery_on(auto_fault_recovery_q),
				.recovery_rearm(rearm_q),
				.unmute_cmd(hit && (g < NFAULT ? (tx_mute_set && !tx_mute_val)
					: (rx_mute_set && !rx_mute_val))),
				.latched_q(latched[g]),
				.limit_hit_q(limit_hit[g])
			);
		end
	endgenerate
	wire tx_fault;
	wire rx_fault;
	assign tx_fault = |latched[NFAULT-1:0];
	assign rx_fault = |latched[2*NFAULT-1:NFAULT];
	// ==========================================================
	// Warm-up hold timer
	reg [31:0] tick_q;
	reg [15:0] sec_q;
	reg [1:0] power_up_q;
	reg tx_power_q;
	reg [9:0] lna_ref_q;
	reg [6:0] win_q;
	reg relay_sel_q;
	reg [10:0] dev_d;
	reg [16:0] lim_d;
	always @* begin
		dev_d = (cur3_q > lna_ref_q) ? {1'b0, cur3_q - lna_ref_q} : {1'b0, lna_ref_q - cur3_q};
		lim_d = lna_ref_q * win_q;
	end
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			whe1_q <= 1'b0;
			whe2_q <= 1'b0;
			ofl1_q <= 1'b0;
			ofl2_q <= 1'b0;
			cur1_q <= 10'h000;
			cur2_q <= 10'h000;
			cur3_q <= 10'h000;
			tick_q <= 32'h0;
			sec_q <= 16'h0;
			power_up_q <= 2'h3;
			hold_active_q <= 1'b0;
			auto_fault_recovery_q <= 1'b0;
			rearm_q <= 1'b0;
			lna_feed_source_on <= 1'b0;
			lna_ref_q <= 10'h000;
			win_q <= `OMFC_WIN_OFF;
			relay_sel_q <= 1'b0;
			lna_alarm_q <= 1'b0;
			summary_fault_q <= 1'b0;
			redundancy_mode_q <= `OMFC_MODE_AUTO;
			redundancy_toggle_q <= 1'b0;
			unit_address_q <= `OMFC_ADDR_RST;
			link_rate_q <= `OMFC_RATE_RST;
			tx_power_q <= 1'b0;
			tx_output_muted <= 1'b1;
			rx_output_muted <= 1'b1;
			tx_output_on_q <= 1'b0;
			rx_output_on_q <= 1'b0;
			stamp_date_q <= 24'h000000;
			stamp_hms_q <= 17'h00000;
			stamp_valid_q <= 1'b0;
		end else begin
			whe1_q <= warmup_hold_enable;
			whe2_q <= whe1_q;
			ofl1_q <= other_fault_pin;
			ofl2_q <= ofl1_q;
			cur1_q <= lna_current;
			cur2_q <= cur1_q;
			// Word taken only when two samples agree
			if (cur2_q == cur1_q)
				cur3_q <= cur2_q;
			// Hold kept until enable synchroniser filled
			power_up_q <= {power_up_q[0], 1'b0};
			// [RULE1] Hold from power-on
			if (power_up_q[1]) begin
				hold_active_q <= 1'b1;
			// [RULE4] Option cleared ends hold
			end else if (!whe2_q) begin
				hold_active_q <= 1'b0;
			end else if (hold_active_q) begin
				if (tick_q == TICK_CYCLES - 1) begin
					tick_q <= 32'h0;
					sec_q <= sec_q + 16'h1;
					// [RULE3] Hold expiry
					if (sec_q == HOLD_SECONDS - 1)
						hold_active_q <= 1'b0;
				end else begin
					tick_q <= tick_q + 32'h1;
				end
			end
			rearm_q <= 1'b0;
			// [RULE7] Limit clears recovery
			if (|limit_hit) begin
				auto_fault_recovery_q <= 1'b0;
			end else if (hit && auto_fault_recovery_set) begin
				auto_fault_recovery_q <= auto_fault_recovery_val;
				// [RULE22] Rearm counters
				rearm_q <= auto_fault_recovery_val && !auto_fault_recovery_q;
			end
			// [RULE8] Feed source switch
			if (hit && lna_feed_source_set)
				lna_feed_source_on <= lna_feed_source_val;
			// [RULE9] Calibrate reference
			if (hit && lna_calibrate)
				lna_ref_q <= cur3_q;
			// [RULE9] Window range
			if (hit && lna_window_width_set && ((lna_window_width_val >= `OMFC_WIN_MIN &&
				lna_window_width_val <= `OMFC_WIN_MAX) || lna_window_width_val == `OMFC_WIN_OFF))
				win_q <= lna_window_width_val;
			// [RULE10] Window off at 99
			lna_alarm_q <= lna_feed_source_on && (win_q != `OMFC_WIN_OFF) &&
				({dev_d, 6'h00} + {1'b0, dev_d, 5'h00} + {4'h0, dev_d, 2'h0} > {1'b0, lim_d});
			if (hit && lna_alarm_relay_select_set)
				relay_sel_q <= lna_alarm_relay_select_val;
			// [RULE11] Relay select
			summary_fault_q <= tx_fault || rx_fault || ofl2_q || (relay_sel_q && lna_alarm_q);
			// [RULE15] Mode forwarded
			if (hit && redundancy_mode_set)
				redundancy_mode_q <= redundancy_mode_val;
			redundancy_toggle_q <= hit && redundancy_toggle;
			// [RULE18] Address range
			if (hit && unit_address_set && unit_address_val >= `OMFC_ADDR_MIN &&
				unit_address_val <= `OMFC_ADDR_MAX)
				unit_address_q <= unit_address_val;
			// [RULE19] Rate select
			if (hit && link_rate_set && link_rate_val <= `OMFC_RATE_38400)
				link_rate_q <= link_rate_val;
			if (hit && tx_power_stage_set)
				tx_power_q <= tx_power_stage_val;
			if (hit && tx_mute_set)
				tx_output_muted <= tx_mute_val;
			if (hit && rx_mute_set)
				rx_output_muted <= rx_mute_val;
			// [RULE21] Output enables
			// [RULE2] Hold mutes both
			tx_output_on_q <= !tx_fault && !tx_output_muted && tx_power_q && !hold_active_q;
			rx_output_on_q <= !rx_fault && !rx_output_muted && !hold_active_q;
			// [RULE20] Event stamping
			if (hit && calendar_date_set)
				stamp_date_q <= calendar_date_val;
			if (hit && clock_hms_set)
				stamp_hms_q <= clock_hms_val;
			stamp_valid_q <= log_event || (|limit_hit) || (lna_alarm_q && !summary_fault_q);
		end
	end
endmodule // omfc_top
`default_nettype wire

// file: verification/omfc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Port checker
module omfc_checker (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic cmd_valid,
	input wire logic [13:0] cmd_address,
	input wire logic warmup_hold_enable,
	input wire logic redundancy_mode_set,
	input wire logic redundancy_mode_val,
	input wire logic redundancy_toggle,
	input wire logic tx_output_on_q,
	input wire logic rx_output_on_q,
	input wire logic tx_output_muted,
	input wire logic rx_output_muted,
	input wire logic hold_active_q,
	input wire logic redundancy_mode_q,
	input wire logic redundancy_toggle_q,
	input wire logic [13:0] unit_address_q,
	input wire logic [2:0] link_rate_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_mode;
		cmd_valid && cmd_address == unit_address_q && redundancy_mode_set;
	endsequence
	sequence s_tog;
		cmd_valid && cmd_address == unit_address_q && redundancy_toggle;
	endsequence
	sequence s_cold;
		!warmup_hold_enable [*5];
	endsequence
	a_hold_mutes_out:
		assert property (hold_active_q |-> !tx_output_on_q && !rx_output_on_q) else $error("on in hold");
	a_tx_needs_unmute:
		assert property (tx_output_on_q |-> !$past(tx_output_muted)) else $error("tx on muted");
	a_rx_needs_unmute:
		assert property (rx_output_on_q |-> !$past(rx_output_muted)) else $error("rx on muted");
	a_foreign_addr:
		assert property (cmd_valid && cmd_address != unit_address_q |=> $stable(link_rate_q)
			&& $stable(unit_address_q) && $stable(redundancy_mode_q)) else $error("foreign taken");
	a_rate_range:
		assert property (link_rate_q <= 3'h5) else $error("rate out of range");
	a_mode_forward:
		assert property (s_mode |=> redundancy_mode_q == $past(redundancy_mode_val))
			else $error("mode not taken");
	a_toggle_forward:
		assert property (s_tog |=> redundancy_toggle_q) else $error("toggle not sent");
	a_toggle_pulse:
		assert property (!(cmd_valid && cmd_address == unit_address_q && redundancy_toggle)
			|=> !redundancy_toggle_q) else $error("toggle without command");
	a_hold_cleared:
		assert property (s_cold |=> !hold_active_q) else $error("hold not ended");
endmodule // omfc_checker

bind omfc_top omfc_checker u_chk (.clk_sys, .reset_n, .cmd_valid, .cmd_address,
	.warmup_hold_enable, .redundancy_mode_set, .redundancy_mode_val, .redundancy_toggle,
	.tx_output_on_q, .rx_output_on_q, .tx_output_muted, .rx_output_muted, .hold_active_q,
	.redundancy_mode_q, .redundancy_toggle_q, .unit_address_q, .link_rate_q);
`default_nettype wire

// file: verification/omfc_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Switch unit model
module omfc_switch_model (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic mode_auto,
	input wire logic toggle,
	input wire logic online_fault,
	input wire logic offline_fault,
	output logic swapped_q
);
	logic auto_q;
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			auto_q <= 1'b1;
			swapped_q <= 1'b0;
		end else begin
			auto_q <= mode_auto;
			if (toggle && (!auto_q || !offline_fault))
				swapped_q <= !swapped_q;
			else if (auto_q && online_fault && !offline_fault && !swapped_q)
				swapped_q <= 1'b1;
		end
	end
endmodule // omfc_switch_model
`default_nettype wire

// file: verification/omfc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("Error %s exp %0h got %0h", n, e, g); end end
// ========
// Bench
module omfc_top_test;
	logic clk_sys = 0, reset_n = 0, cmd_valid, warmup_hold_enable, off_fault, s;
	logic auto_fault_recovery_set, auto_fault_recovery_val, lna_feed_source_set;
	logic lna_feed_source_val, lna_calibrate, lna_window_width_set, lna_alarm_relay_select_set;
	logic lna_alarm_relay_select_val, redundancy_mode_set, redundancy_mode_val, redundancy_toggle;
	logic unit_address_set, link_rate_set, calendar_date_set, clock_hms_set, tx_power_stage_set;
	logic tx_power_stage_val, tx_mute_set, tx_mute_val, rx_mute_set, rx_mute_val;
	logic other_fault_pin, log_event, tx_output_on_q, rx_output_on_q, tx_output_muted;
	logic rx_output_muted, hold_active_q, auto_fault_recovery_q, lna_feed_source_on;
	logic lna_alarm_q, summary_fault_q, redundancy_mode_q, redundancy_toggle_q, stamp_valid_q;
	logic swapped_q;
	logic [13:0] cmd_address, unit_address_val, unit_address_q;
	logic [6:0] lna_window_width_val;
	logic [2:0] link_rate_val, link_rate_q;
	logic [23:0] calendar_date_val, stamp_date_q;
	logic [16:0] clock_hms_val, stamp_hms_q;
	logic [3:0] tx_fault_pin, rx_fault_pin;
	logic [9:0] lna_current;
	logic [31:0] lf = 32'hF022;
	int fails = 0, samples_checked = 0, n, rf;
	omfc_top #(.HOLD_SECONDS(3), .TICK_CYCLES(4)) dut (.*);
	omfc_switch_model u_rsu (.clk_sys, .reset_n, .mode_auto(redundancy_mode_q),
		.toggle(redundancy_toggle_q), .online_fault(summary_fault_q), .offline_fault(off_fault),
		.swapped_q);
	always #25 clk_sys = !clk_sys;
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic exp_alarm(input int c, input int r, input int w);
		return w != 99 && (c > r ? c - r : r - c) * 100 > r * w;
	endfunction
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic clr();
		{cmd_valid, auto_fault_recovery_set, lna_feed_source_set, lna_calibrate,
			lna_window_width_set, lna_alarm_relay_select_set, redundancy_mode_set,
			redundancy_toggle, unit_address_set, link_rate_set, calendar_date_set, clock_hms_set,
			tx_power_stage_set, tx_mute_set, rx_mute_set, log_event} = '0;
	endtask
	task automatic cmd(input logic [13:0] a, input int k, input logic [23:0] v);
		cmd_valid = 1;
		cmd_address = a;
		case (k)
			0: {tx_mute_set, tx_mute_val} = {1'b1, v[0]};
			1: {rx_mute_set, rx_mute_val} = {1'b1, v[0]};
			2: {tx_power_stage_set, tx_power_stage_val} = {1'b1, v[0]};
			3: {auto_fault_recovery_set, auto_fault_recovery_val} = {1'b1, v[0]};
			4: {lna_feed_source_set, lna_feed_source_val} = {1'b1, v[0]};
			5: {lna_window_width_set, lna_window_width_val} = {1'b1, v[6:0]};
			6: {lna_alarm_relay_select_set, lna_alarm_relay_select_val} = {1'b1, v[0]};
			7: {redundancy_mode_set, redundancy_mode_val} = {1'b1, v[0]};
			8: {unit_address_set, unit_address_val} = {1'b1, v[13:0]};
			9: {link_rate_set, link_rate_val} = {1'b1, v[2:0]};
			10: {calendar_date_set, calendar_date_val} = {1'b1, v};
			11: {clock_hms_set, clock_hms_val} = {1'b1, v[16:0]};
			12: lna_calibrate = 1;
			default: redundancy_toggle = 1;
		endcase
		tick(1);
		clr();
		tick(1);
	endtask
	task automatic pulse_rx();
		rx_fault_pin[1] = 1;
		tick(6);
		rx_fault_pin[1] = 0;
		tick(6);
	endtask
	task automatic print_verdict();
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		clr();
		{auto_fault_recovery_val, lna_feed_source_val, lna_alarm_relay_select_val,
			redundancy_mode_val, tx_power_stage_val, tx_mute_val, rx_mute_val, other_fault_pin,
			tx_fault_pin, rx_fault_pin, lna_current, cmd_address, unit_address_val,
			lna_window_width_val, link_rate_val, calendar_date_val, clock_hms_val} = '0;
		{warmup_hold_enable, off_fault} = 2'h3;
		tick(12);
		reset_n = 1;
		`CHK("dflt", 19'h0C001, {lna_feed_source_on, auto_fault_recovery_q, link_rate_q,
			unit_address_q})
		cmd(1, 0, 0);
		cmd(1, 1, 0);
		cmd(1, 2, 1);
		`CHK("hold_mute", 3'h4, {hold_active_q, tx_output_on_q, rx_output_on_q})
		n = 6;
		while (hold_active_q !== 1'b0 && n < 40) begin
			tick(1);
			n++;
		end
		`CHK("hold_len", 1'b1, n >= 12 && n <= 18)
		tick(2);
		`CHK("on", 2'h3, {tx_output_on_q, rx_output_on_q})
		tx_fault_pin[0] = 1;
		tick(6);
		`CHK("tx_flt", 1'b0, tx_output_on_q)
		tx_fault_pin[0] = 0;
		tick(6);
		`CHK("tx_held", 1'b0, tx_output_on_q)
		cmd(1, 0, 0);
		tick(2);
		`CHK("tx_back", 1'b1, tx_output_on_q)
		cmd(1, 3, 1);
		for (int i = 1; i <= 6; i++) begin
			pulse_rx();
			`CHK("rx_auto", i < 5, rx_output_on_q)
			`CHK("afr_lim", i < 5, auto_fault_recovery_q)
		end
		cmd(1, 1, 0);
		cmd(1, 3, 1);
		pulse_rx();
		`CHK("rearm", 2'h3, {auto_fault_recovery_q, rx_output_on_q})
		lf = nx(lf);
		cmd(14'h2 + {1'b0, lf[12:0]}, 9, 5);
		`CHK("foreign", 3'h3, link_rate_q)
		for (int r = 0; r < 8; r++) begin
			cmd(1, 9, 24'(r));
			`CHK("rate_set", r < 6 ? r : 5, link_rate_q)
		end
		cmd(1, 8, 0);
		cmd(1, 8, 9999);
		cmd(1, 9, 0);
		`CHK("addr_max", 17'h1670F, {link_rate_q, unit_address_q})
		cmd(9999, 8, 1);
		cmd(1, 4, 1);
		`CHK("feed_on", 1'b1, lna_feed_source_on)
		cmd(1, 5, 40);
		lf = nx(lf);
		rf = 100 + lf[7:0];
		lna_current = 10'(rf);
		tick(4);
		cmd(1, 12, 0);
		for (int i = 0; i < 6; i++) begin
			lf = nx(lf);
			lna_current = i == 0 ? 10'(2 * rf) : lf[9:0];
			tick(6);
			`CHK("alarm", exp_alarm(lna_current, rf, 40), lna_alarm_q)
		end
		lna_current = 10'(2 * rf);
		cmd(1, 5, 60);
		tick(4);
		`CHK("relay_off", 2'h2, {lna_alarm_q, summary_fault_q})
		cmd(1, 6, 1);
		tick(2);
		`CHK("relay_on", 2'h3, {lna_alarm_q, summary_fault_q})
		cmd(1, 5, 99);
		tick(4);
		`CHK("win_off", 2'h0, {lna_alarm_q, summary_fault_q})
		cmd(1, 7, 0);
		s = swapped_q;
		cmd(1, 13, 0);
		tick(2);
		`CHK("man_tog", {1'b0, !s}, {redundancy_mode_q, swapped_q})
		cmd(1, 7, 1);
		s = swapped_q;
		cmd(1, 13, 0);
		tick(2);
		`CHK("auto_tog", {1'b1, s}, {redundancy_mode_q, swapped_q})
		off_fault = 0;
		cmd(1, 13, 0);
		tick(2);
		`CHK("auto_tog_ok", !s, swapped_q)
		other_fault_pin = 1;
		tick(6);
		`CHK("failover", 2'h3, {summary_fault_q, swapped_q})
		other_fault_pin = 0;
		tick(4);
		lf = nx(lf);
		cmd(1, 10, lf[23:0]);
		cmd(1, 11, {7'h0, lf[16:0]});
		log_event = 1;
		tick(1);
		log_event = 0;
		for (n = 0; stamp_valid_q !== 1'b1 && n < 4; n++)
			tick(1);
		`CHK("stamp", {1'b1, lf[23:0], lf[16:0]}, {stamp_valid_q, stamp_date_q,
			stamp_hms_q})
		reset_n = 0;
		tick(2);
		reset_n = 1;
		tick(3);
		`CHK("hold2", 1'b1, hold_active_q)
		warmup_hold_enable = 0;
		tick(7);
		`CHK("hold_off", 1'b0, hold_active_q)
		print_verdict();
	end
endmodule // omfc_top_test
`default_nettype wire
